/* File: ceni_ctl_endpoint.sv */
// Control endpoint arming, status-phase hold, halt and IN-NAK event flags.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ceni_map.svh"

module ceni_ctl_endpoint
   import ceni_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [17:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tokValid,
   input wire ceni_tok_t tokKind,
   input wire logic [2:0] tokEp,
   input wire logic tokStatus,
   input wire logic [7:1] inArmed,
   input wire logic ctlInDone,
   input wire logic ctlOutDone,
   output logic hsValid,
   output var ceni_hs_t hsCode,
   output logic [6:0] inCount,
   output logic [6:0] outCount,
   output logic [15:0] setupPtr,
   output logic irq
);
   // =======================================================================
   // Bus slave
   // =======================================================================
   logic busAck_r;
   logic [31:0] readData_r;
   logic [31:0] readMux;
   wire [15:0] wordIdx = avs_address[17:2];
   wire reqActive = avs_read | avs_write;
   wire selEvtReq = (wordIdx == `CENI_IDX_EVT_REQ);
   wire selEvtEn = (wordIdx == `CENI_IDX_EVT_EN);
   wire selNakReq = (wordIdx == `CENI_IDX_NAK_REQ);
   wire selNakEn = (wordIdx == `CENI_IDX_NAK_EN);
   wire selCs = (wordIdx == `CENI_IDX_CTL_CS);
   wire selInCnt = (wordIdx == `CENI_IDX_IN_CNT);
   wire selOutCnt = (wordIdx == `CENI_IDX_OUT_CNT);
   wire selPtr = (wordIdx == `CENI_IDX_SETUP_PTR);
   // A write lands on the edge where waitrequest is seen low.
   wire wrCommit = avs_write & busAck_r;
   wire wrLow = wrCommit & avs_byteenable[0];
   wire wrHigh = wrCommit & avs_byteenable[1];

   assign avs_waitrequest = reqActive & ~busAck_r;
   assign avs_readdata = readData_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busAck_r <= 1'b0;
         readData_r <= 32'h00000000;
      end else if (ce) begin
         busAck_r <= reqActive & ~busAck_r;
         if (avs_read && !busAck_r) begin
            readData_r <= readMux;
         end
      end
   end

   // =======================================================================
   // Token decode
   // =======================================================================
   wire tokHere = tokValid & ce;
   wire isSetup = tokHere & (tokKind == CENI_TOK_SETUP);
   wire isCtl = tokHere & (tokEp == 3'h0) & (tokKind != CENI_TOK_SETUP) &
      (tokKind != CENI_TOK_NONE);
   wire isCtlIn = isCtl & (tokKind == CENI_TOK_IN);
   wire isCtlOut = isCtl & (tokKind == CENI_TOK_OUT);
   wire isBulkIn = tokHere & (tokKind == CENI_TOK_IN) & (tokEp != 3'h0);

   // =======================================================================
   // Control endpoint state
   // =======================================================================
   logic outBusy_r;
   logic inBusy_r;
   logic halt_r;
   logic holdFlag;
   logic [6:0] inCount_r;
   logic [6:0] outCount_r;
   logic [15:0] setupPtr_r;

   wire wrOutCnt = wrLow & selOutCnt;
   wire wrInCnt = wrLow & selInCnt;
   wire wrPtr = (wrLow | wrHigh) & selPtr;
   wire wrCs = wrLow & selCs;
   wire ctlDataNak = (isCtlIn & ~tokStatus & ~halt_r & ~inBusy_r);

   // A new SETUP aborts whatever the firmware was arming, so it wins over
   // a bus write landing in the same cycle.
   wire outBusy_nxt = isSetup ? 1'b0 :
      (wrOutCnt ? 1'b1 :
      (ctlOutDone ? 1'b0 : outBusy_r));
   wire inBusy_nxt = isSetup ? 1'b0 :
      ((wrInCnt | wrPtr) ? 1'b1 :
      (ctlInDone ? 1'b0 : inBusy_r));
   wire halt_nxt = isSetup ? 1'b0 :
      ((wrCs & avs_writedata[`CENI_CS_HALT_BIT]) ? 1'b1 : halt_r);

   // The hold bit behaves like any sticky event flag: SETUP sets, a one clears.
   ceni_nak_flag holdCell (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .setEvent(isSetup),
      .clearWrite(wrCs & avs_writedata[`CENI_CS_HOLD_BIT]),
      .flag(holdFlag)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         outBusy_r <= `CENI_OUT_BUSY_RST;
         inBusy_r <= 1'b0;
         halt_r <= 1'b0;
      end else if (ce) begin
         outBusy_r <= outBusy_nxt;
         inBusy_r <= inBusy_nxt;
         halt_r <= halt_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         inCount_r <= `CENI_CNT_RST;
         outCount_r <= `CENI_CNT_RST;
         setupPtr_r <= `CENI_PTR_RST;
      end else if (ce) begin
         if (wrInCnt) begin
            inCount_r <= avs_writedata[6:0];
         end
         if (wrOutCnt) begin
            outCount_r <= avs_writedata[6:0];
         end
         if (wrLow && selPtr) begin
            setupPtr_r[7:0] <= avs_writedata[7:0];
         end
         if (wrHigh && selPtr) begin
            setupPtr_r[15:8] <= avs_writedata[15:8];
         end
      end
   end

   assign inCount = inCount_r;
   assign outCount = outCount_r;
   assign setupPtr = setupPtr_r;

   // =======================================================================
   // Handshake answer
   // =======================================================================
   logic hsValid_r;
   ceni_hs_t hsCode_r;
   ceni_hs_t hsCode_nxt;
   // Endpoint zero has no bulk arming input; a zero there keeps the index in range.
   wire [7:0] armedAll = {inArmed, 1'b0};
   wire bulkArmed = armedAll[tokEp];
   wire bulkNak = isBulkIn & ~bulkArmed;

   // Halt outranks the hold bit: otherwise a halted endpoint with hold set would still
   // NAK the status stage and the host would retry forever.
   always_comb begin
      hsCode_nxt = CENI_HS_NAK;
      if (isSetup) begin
         hsCode_nxt = CENI_HS_ACK;
      end else if (isCtl && halt_r) begin
         hsCode_nxt = CENI_HS_STALL;
      end else if (isCtl && tokStatus) begin
         hsCode_nxt = holdFlag ? CENI_HS_NAK : CENI_HS_ACK;
      end else if (isCtlIn) begin
         hsCode_nxt = inBusy_r ? CENI_HS_DATA : CENI_HS_NAK;
      end else if (isCtlOut) begin
         hsCode_nxt = outBusy_r ? CENI_HS_ACK : CENI_HS_NAK;
      end else if (isBulkIn) begin
         hsCode_nxt = bulkArmed ? CENI_HS_DATA : CENI_HS_NAK;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hsValid_r <= 1'b0;
         hsCode_r <= CENI_HS_ACK;
      end else if (ce) begin
         hsValid_r <= isSetup | isCtl | isBulkIn;
         hsCode_r <= hsCode_nxt;
      end
   end

   assign hsValid = hsValid_r;
   assign hsCode = hsCode_r;

   // =======================================================================
   // IN-NAK event flags and interrupt
   // =======================================================================
   logic [6:0] nakFlags;
   logic [6:0] enableMask_r;
   logic summaryEnable_r;
   logic summaryFlag;
   logic [6:0] nakEvent;

   genvar ep;
   generate
      for (ep = 0; ep < `CENI_NAK_EPS; ep = ep + 1) begin : gNak
         // Endpoint zero counts as unarmed while its IN data phase is idle.
         if (ep == 0) begin : gCtl
            assign nakEvent[ep] = ctlDataNak;
         end else begin : gBulk
            assign nakEvent[ep] = isBulkIn & (tokEp == 3'(ep)) & ~inArmed[ep];
         end
         ceni_nak_flag flagCell (
            .clock(clock),
            .rst_n(rst_n),
            .ce(ce),
            .setEvent(nakEvent[ep]),
            .clearWrite(wrLow & selNakReq & avs_writedata[ep]),
            .flag(nakFlags[ep])
         );
      end
   endgenerate

   ceni_nak_flag summaryCell (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .setEvent(|nakEvent | bulkNak),
      .clearWrite(wrLow & selEvtReq & avs_writedata[`CENI_EVT_NAK_BIT]),
      .flag(summaryFlag)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enableMask_r <= `CENI_NAK_EN_RST;
         summaryEnable_r <= 1'b0;
      end else if (ce) begin
         if (wrLow && selNakEn) begin
            enableMask_r <= avs_writedata[6:0];
         end
         if (wrLow && selEvtEn) begin
            summaryEnable_r <= avs_writedata[`CENI_EVT_NAK_BIT];
         end
      end
   end

   // Flags are kept whatever the enables say; only the request is gated.
   assign irq = summaryEnable_r & |(nakFlags & enableMask_r);
   // Only a new event or an enable write may raise the request.
   wire irqCause = |nakEvent | (wrLow & (selNakEn | selEvtEn));

   // =======================================================================
   // Read multiplexer
   // =======================================================================
   wire [7:0] csView = {4'h0, outBusy_r, inBusy_r, holdFlag, halt_r};
   wire [7:0] evtReqView = {2'h0, summaryFlag, 5'h00};
   wire [7:0] evtEnView = {2'h0, summaryEnable_r, 5'h00};

   always_comb begin
      readMux = 32'h00000000;
      if (selEvtReq) begin
         readMux = {24'h000000, evtReqView};
      end else if (selEvtEn) begin
         readMux = {24'h000000, evtEnView};
      end else if (selNakReq) begin
         readMux = {25'h0, nakFlags};
      end else if (selNakEn) begin
         readMux = {25'h0, enableMask_r};
      end else if (selCs) begin
         readMux = {24'h000000, csView};
      end else if (selInCnt) begin
         readMux = {25'h0, inCount_r};
      end else if (selOutCnt) begin
         readMux = {25'h0, outCount_r};
      end else if (selPtr) begin
         readMux = {16'h0000, setupPtr_r};
      end
   end

   // =======================================================================
   // Checks
   // =======================================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_setup_clears_state: assert property (
      isSetup |=> !outBusy_r && !inBusy_r && holdFlag && !halt_r)
      else $error("SETUP did not reset control endpoint state");

   a_out_count_arms: assert property (
      wrOutCnt && !isSetup |=> outBusy_r && outCount_r == $past(avs_writedata[6:0]))
      else $error("OUT byte count write did not arm OUT");

   a_in_arming: assert property (
      (wrInCnt || wrPtr) && !isSetup |=> inBusy_r ##1 (!ce || ctlInDone || isSetup || inBusy_r))
      else $error("IN arming write did not set IN busy");

   a_halt_stalls: assert property (
      isCtl && halt_r |=> hsValid && hsCode == CENI_HS_STALL)
      else $error("halted control endpoint did not STALL");

   a_status_hold: assert property (
      isCtl && tokStatus && !halt_r |=> hsValid &&
         hsCode == ($past(holdFlag) ? CENI_HS_NAK : CENI_HS_ACK))
      else $error("status stage answer does not follow hold bit");

   a_ctl_unarmed_nak: assert property (
      (isCtlIn && !inBusy_r || isCtlOut && !outBusy_r) && !tokStatus && !halt_r
         |=> hsCode == CENI_HS_NAK)
      else $error("unarmed control data token not NAKed");

   a_bulk_nak_flag: assert property (
      isBulkIn && tokEp < 3'h7 && !bulkArmed |=> hsCode == CENI_HS_NAK &&
         nakFlags[$past(tokEp)] && summaryFlag)
      else $error("unarmed bulk IN did not NAK and flag");

   a_zero_write_keeps: assert property (
      wrLow && selNakReq && ce |=> nakFlags ==
         (($past(nakFlags) & ~$past(avs_writedata[6:0])) | $past(nakEvent)))
      else $error("request flag write did not clear exactly the ones");

   a_irq_needs_enable: assert property (
      irq |-> summaryEnable_r && (nakFlags & enableMask_r) != 7'h00)
      else $error("interrupt raised without enables");

   a_irq_has_cause: assert property (
      $rose(irq) |-> $past(irqCause))
      else $error("interrupt rose without a NAK event or enable write");

   a_hold_clear: assert property (
      wrCs && avs_writedata[`CENI_CS_HOLD_BIT] && !isSetup |=> !holdFlag)
      else $error("writing one did not clear hold");

endmodule : ceni_ctl_endpoint

`default_nettype wire

/* File: ceni_map.svh */
// Register indices, field positions and reset values of the control endpoint block.
`ifndef CENI_MAP_SVH
`define CENI_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define CENI_IDX_EVT_REQ 16'h7FAB
`define CENI_IDX_EVT_EN 16'h7FAE
`define CENI_IDX_NAK_REQ 16'h7FB0
`define CENI_IDX_NAK_EN 16'h7FB1
`define CENI_IDX_CTL_CS 16'h7FB4
`define CENI_IDX_IN_CNT 16'h7FB5
`define CENI_IDX_OUT_CNT 16'h7FC5
`define CENI_IDX_SETUP_PTR 16'h7FD4

// ==========================================================================
// Field positions
// ==========================================================================
`define CENI_EVT_NAK_BIT 5
`define CENI_CS_OUT_BUSY_BIT 3
`define CENI_CS_IN_BUSY_BIT 2
`define CENI_CS_HOLD_BIT 1
`define CENI_CS_HALT_BIT 0
`define CENI_NAK_EPS 7
`define CENI_CNT_W 7

// ==========================================================================
// Reset values
// ==========================================================================
`define CENI_OUT_BUSY_RST 1'b1
`define CENI_CNT_RST 7'h00
`define CENI_NAK_EN_RST 7'h00
`define CENI_PTR_RST 16'h0000

`endif

/* File: ceni_pkg.sv */
// Types shared by the control endpoint block and its users.
package ceni_pkg;

   // =======================================================================
   // Token kinds from the serial interface engine and handshake answers
   // =======================================================================
   typedef enum logic [1:0] {CENI_TOK_OUT, CENI_TOK_IN, CENI_TOK_SETUP, CENI_TOK_NONE} ceni_tok_t;
   typedef enum logic [1:0] {CENI_HS_ACK, CENI_HS_NAK, CENI_HS_STALL, CENI_HS_DATA} ceni_hs_t;

endpackage : ceni_pkg

/* File: ceni_nak_flag.sv */
// Sticky flag that hardware sets and software clears by writing one.
`timescale 1ns/1ps
`default_nettype none

module ceni_nak_flag (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic setEvent,
   input wire logic clearWrite,
   output logic flag
);
   logic flag_r;
   logic flag_nxt;

   // An event in the same cycle as a clear must not be lost, so set wins.
   assign flag_nxt = setEvent ? 1'b1 : (clearWrite ? 1'b0 : flag_r);
   assign flag = flag_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end

endmodule : ceni_nak_flag

`default_nettype wire

/* File: ceni_usb_host.sv */
// Host-side model that issues tokens and captures the handshake answer.
`timescale 1ns/1ps
`default_nettype none

module ceni_usb_host
   import ceni_pkg::*;
(
   input wire logic clock,
   output logic tokValid,
   output var ceni_tok_t tokKind,
   output logic [2:0] tokEp,
   output logic tokStatus,
   input wire logic hsValid,
   input wire ceni_hs_t hsCode
);
   initial begin
      tokValid = 1'b0;
      tokKind = CENI_TOK_NONE;
      tokEp = 3'h0;
      tokStatus = 1'b0;
   end

   // ======================================================================
   // One token a call: d[1:0] kind, d[4:2] endpoint, d[5] status stage.
   // ======================================================================
   task automatic send(input logic [7:0] d, output logic v, output ceni_hs_t c);
      @(posedge clock);
      tokValid <= 1'b1;
      tokKind <= ceni_tok_t'(d[1:0]);
      tokEp <= d[4:2];
      tokStatus <= d[5];
      @(posedge clock);
      tokValid <= 1'b0;
      // Released fields are scrambled so a stale token cannot look valid.
      tokKind <= CENI_TOK_NONE;
      tokEp <= ~d[4:2];
      tokStatus <= ~d[5];
      @(negedge clock);
      v = hsValid;
      c = hsCode;
   endtask : send
endmodule : ceni_usb_host

`default_nettype wire

/* File: ceni_ctl_endpoint_tb.sv */
// Self-checking bench for the control endpoint and IN-NAK flag block.
`timescale 1ns/1ps
`default_nettype none
`include "ceni_map.svh"

`define CENI_CHK(g, x) begin \
   num_checks++; \
   if ((g) !== (x)) begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (x)); \
   end \
end

module ceni_ctl_endpoint_tb import ceni_pkg::*;;
   typedef struct packed {int op; logic [15:0] a; logic [31:0] d; logic [31:0] e;} ceni_row_t;
   localparam int W = 0, R = 1, T = 2, A = 3, Q = 4;
   localparam logic [15:0] CS = `CENI_IDX_CTL_CS, IC = `CENI_IDX_IN_CNT;
   localparam logic [15:0] OC = `CENI_IDX_OUT_CNT, NQ = `CENI_IDX_NAK_REQ;
   localparam logic [15:0] NE = `CENI_IDX_NAK_EN, EQ = `CENI_IDX_EVT_REQ;
   localparam logic [15:0] EE = `CENI_IDX_EVT_EN, SP = `CENI_IDX_SETUP_PTR;
   localparam logic [15:0] UN = 16'h7FC4;

   logic clock;
   logic rst_n;
   logic ce;
   logic [17:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic tokValid;
   ceni_tok_t tokKind;
   logic [2:0] tokEp;
   logic tokStatus;
   logic [7:1] inArmed;
   logic ctlInDone;
   logic ctlOutDone;
   logic hsValid;
   ceni_hs_t hsCode;
   logic [6:0] inCount;
   logic [6:0] outCount;
   logic [15:0] setupPtr;
   logic irq;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   logic v;
   ceni_hs_t c;
   logic [31:0] rd;

   // Token codes: 02 setup, 01 IN, 00 OUT, +20 status stage; 4 means no answer.
   ceni_row_t rows[53] = '{
      '{R,CS,0,8'h08}, '{R,NQ,0,0}, '{Q,0,0,0}, '{T,0,8'h02,0},
      '{R,CS,0,8'h02}, '{T,0,8'h01,1}, '{T,0,8'h00,1},
      '{T,0,8'h21,1}, '{W,OC,8'h05,0}, '{R,CS,0,8'h0A},
      '{R,OC,0,8'h05}, '{T,0,8'h00,0}, '{W,IC,8'h10,0},
      '{R,CS,0,8'h0E}, '{T,0,8'h01,3}, '{W,CS,8'h02,0},
      '{R,CS,0,8'h0C}, '{T,0,8'h20,0}, '{W,CS,8'h01,0},
      '{R,CS,0,8'h0D}, '{T,0,8'h01,2}, '{T,0,8'h20,2},
      '{T,0,8'h00,2}, '{T,0,8'h02,0}, '{R,CS,0,8'h02},
      '{W,CS,8'h0C,0}, '{R,CS,0,8'h02}, '{W,SP,16'h1234,0},
      '{R,SP,0,16'h1234}, '{T,0,8'h01,3}, '{T,0,8'h0D,1},
      '{A,0,8'h08,0}, '{T,0,8'h0D,3}, '{T,0,8'h08,4},
      '{R,NQ,0,8'h09}, '{R,EQ,0,8'h20}, '{W,NE,8'h08,0},
      '{Q,0,0,0}, '{W,EE,8'h20,0}, '{Q,0,0,1},
      '{W,NE,8'h00,0}, '{Q,0,0,0}, '{W,NE,8'h01,0},
      '{Q,0,0,1}, '{W,NQ,8'h00,0}, '{R,NQ,0,8'h09},
      '{W,NQ,8'h01,0}, '{R,NQ,0,8'h08}, '{Q,0,0,0},
      '{W,UN,8'h5A,0}, '{R,UN,0,0}, '{W,EQ,8'h20,0}, '{R,EQ,0,0}
   };

   ceni_ctl_endpoint dut (
      .clock(clock), .rst_n(rst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .tokValid(tokValid), .tokKind(tokKind), .tokEp(tokEp), .tokStatus(tokStatus),
      .inArmed(inArmed), .ctlInDone(ctlInDone), .ctlOutDone(ctlOutDone),
      .hsValid(hsValid), .hsCode(hsCode), .inCount(inCount), .outCount(outCount),
      .setupPtr(setupPtr), .irq(irq)
   );

   ceni_usb_host host (
      .clock(clock), .tokValid(tokValid), .tokKind(tokKind), .tokEp(tokEp),
      .tokStatus(tokStatus), .hsValid(hsValid), .hsCode(hsCode)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ======================================================================
   // Bus access: held until waitrequest is seen low at a rising edge.
   // ======================================================================
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] q);
      @(posedge clock);
      avs_address <= {a, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic results();
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         results();
      end
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      avs_address = 18'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0;
      inArmed = 7'h00;
      ctlInDone = 1'b0;
      ctlOutDone = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         case (rows[i].op)
            W: bus(1'b1, rows[i].a, rows[i].d, 4'h3, rd);
            R: begin
               bus(1'b0, rows[i].a, 0, 4'hF, rd);
               `CENI_CHK(rd, rows[i].e)
            end
            T: begin
               host.send(rows[i].d[7:0], v, c);
               `CENI_CHK(v, rows[i].e != 4)
               if (rows[i].e != 4) `CENI_CHK(c, rows[i].e[1:0])
            end
            A: begin
               @(posedge clock);
               inArmed <= rows[i].d[7:1];
            end
            Q: begin
               @(negedge clock);
               `CENI_CHK(irq, rows[i].e[0])
            end
         endcase
      end
      `CENI_CHK(setupPtr, 16'h1234)
      // Endpoint 7 has no request flag but must still raise the summary bit.
      host.send(8'h1D, v, c);
      `CENI_CHK(c, CENI_HS_NAK)
      bus(1'b0, EQ, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h20)
      // Bulk IN endpoints 1 to 6, left unarmed, must each flag their own bit.
      inArmed <= 7'h00;
      for (int ep = 1; ep < 7; ep++) begin
         host.send({3'h0, ep[2:0], 2'h1}, v, c);
         `CENI_CHK(c, CENI_HS_NAK)
      end
      bus(1'b0, NQ, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h7E)
      bus(1'b1, OC, 8'h01, 4'h1, rd);
      @(posedge clock);
      `CENI_CHK(outCount, 7'h01)
      ctlInDone <= 1'b1;
      ctlOutDone <= 1'b1;
      @(posedge clock);
      ctlInDone <= 1'b0;
      ctlOutDone <= 1'b0;
      bus(1'b0, CS, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h02)
      host.send(8'h00, v, c);
      `CENI_CHK(c, CENI_HS_NAK)
      host.send(8'h01, v, c);
      `CENI_CHK(c, CENI_HS_NAK)
      // Halt set while hold is still one must STALL the status stage.
      bus(1'b1, CS, 8'h01, 4'h1, rd);
      host.send(8'h21, v, c);
      `CENI_CHK(c, CENI_HS_STALL)
      // A write without lane 0 must leave a 7-bit register alone.
      bus(1'b1, IC, 8'h33, 4'h1, rd);
      bus(1'b1, IC, 8'h44, 4'h2, rd);
      bus(1'b0, IC, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h33)
      `CENI_CHK(inCount, 7'h33)
      // With the clock enable low a SETUP must be ignored entirely.
      @(posedge clock);
      ce <= 1'b0;
      host.send(8'h02, v, c);
      `CENI_CHK(v, 1'b0)
      @(posedge clock);
      ce <= 1'b1;
      bus(1'b0, CS, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h07)
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, CS, 0, 4'hF, rd);
      `CENI_CHK(rd, 32'h08)
      `CENI_CHK(irq, 1'b0)
      results();
   end
endmodule : ceni_ctl_endpoint_tb

`default_nettype wire
